// ### src/fmu_pkg.sv
// shared constants and carriers for the float multiply unit
package fmu_pkg;

	localparam logic [7:0] FMU_OPC_MUL       = 8'h1C;
	localparam logic [7:0] FMU_OPC_MUL_FLAGS = 8'h8F;
	localparam logic [2:0] FMU_SLOT_LO       = 3'h2;
	localparam logic [2:0] FMU_SLOT_HI       = 3'h3;
	localparam int         FMU_LATENCY       = 3;

	// exception vector bit positions
	localparam int FMU_B_OFZ = 6;
	localparam int FMU_B_IFZ = 5;
	localparam int FMU_B_INV = 4;
	localparam int FMU_B_OVF = 3;
	localparam int FMU_B_UNF = 2;
	localparam int FMU_B_INX = 1;
	localparam int FMU_B_DBZ = 0;
	localparam int FMU_FLAG_W = 7;

	// status word layout: flags in [6:0], rounding mode in [9:8]
	localparam int FMU_RM_LSB = 8;
	localparam int FMU_RM_MSB = 9;

	// register byte offsets
	localparam logic [11:0] FMU_OFS_PSW      = 12'h000;
	localparam logic [11:0] FMU_OFS_IRQ_STAT = 12'h004;
	localparam logic [11:0] FMU_OFS_IRQ_MASK = 12'h008;

	// interrupt status bits
	localparam int FMU_EV_W    = 3;
	localparam int FMU_EV_WB   = 0;
	localparam int FMU_EV_EXC  = 1;
	localparam int FMU_EV_REFU = 2;

	localparam logic [31:0] FMU_QNAN    = 32'hFFFFFFFF;
	localparam logic [30:0] FMU_MAX_FIN = 31'h7F7FFFFF;
	localparam logic [7:0]  FMU_EXP_MAX = 8'hFF;
	localparam logic [9:0]  FMU_BIAS    = 10'h07F;
	localparam logic signed [9:0] FMU_DENORM_FLOOR = -10'sd22;

	typedef enum logic [1:0] {
		FMU_RM_NEAREST = 2'h0,
		FMU_RM_ZERO    = 2'h1,
		FMU_RM_POS     = 2'h2,
		FMU_RM_NEG     = 2'h3
	} fmu_rmode_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  slot;
		logic [7:0]  opcode;
		logic        guard_used;
		logic        guard_lsb;
		logic [31:0] first_source_register;
		logic [31:0] second_source_register;
		logic [6:0]  dest;
	} fmu_req_t;

	typedef struct packed {
		logic        valid;
		logic [6:0]  dest;
		logic [31:0] data;
	} fmu_wb_t;

endpackage

// ### src/fmu_mul_unit.sv
// single-precision multiply datapath with status word and apb slave
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps

// Function
// [RULE_01] multiply two single-precision operands and write the product to destination
// [RULE_02] both operations deliver their result three cycles after issue
// [RULE_03] multiply operation decoded from operation code 28
// [RULE_04] multiply-flags operation decoded from operation code 143
// [RULE_05] both operations only accepted in issue slots two and three
// [RULE_06] rounding follows rounding-mode field of the status word
// [RULE_07] denormal input becomes zero and sets input-flush flag in status word
// [RULE_08] denormal product becomes zero and sets output-flush flag in status word
// [RULE_09] each ieee exception of multiply sets its status-word flag
// [RULE_10] status-word flags are sticky; only an explicit status write clears them
// [RULE_11] flag update happens in the same cycle as the destination write
// [RULE_12] simultaneous flag updates are ored together with the old value
// [RULE_13] guarded multiply with false guard changes neither destination nor flags
// [RULE_14] multiply-flags writes the flag vector and leaves status flags alone
// [RULE_15] flag vector layout ofz6 ifz5 inv4 ovf3 unf2 inx1 dbz0, rest zero
// [RULE_16] multiply-flags result marks denormal inputs and denormal product
// [RULE_17] guarded multiply-flags with false guard leaves destination unchanged
// [RULE_18] invalid multiply returns all-ones nan and raises invalid flag
module fmu_mul_unit
	import fmu_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire fmu_req_t    req,
	input  wire logic [6:0]  ext_flag_set,
	output fmu_wb_t          wb,
	output logic      [31:0] program_status_word,
	output logic             irq
);

	function automatic logic is_denorm(input logic [31:0] x);
		return (x[30:23] == 8'h00) && (x[22:0] != 23'h0);
	endfunction

	function automatic logic is_zero_exp(input logic [31:0] x);
		return x[30:23] == 8'h00;
	endfunction

	function automatic logic is_inf(input logic [31:0] x);
		return (x[30:23] == FMU_EXP_MAX) && (x[22:0] == 23'h0);
	endfunction

	function automatic logic is_nan(input logic [31:0] x);
		return (x[30:23] == FMU_EXP_MAX) && (x[22:0] != 23'h0);
	endfunction

	// ---------------- issue and stage 1 ----------------
	wire logic slot_ok  = (req.slot == FMU_SLOT_LO) || (req.slot == FMU_SLOT_HI);
	wire logic op_mul   = req.opcode == FMU_OPC_MUL;       // [RULE_03]
	wire logic op_flags = req.opcode == FMU_OPC_MUL_FLAGS; // [RULE_04]
	wire logic accept   = req.valid && slot_ok && (op_mul || op_flags); // [RULE_05]
	wire logic refused  = req.valid && !accept;
	wire logic guard_ok = !req.guard_used || req.guard_lsb; // [RULE_13] [RULE_17]

	logic        s1_valid_r;
	logic        s1_flags_r;
	logic [6:0]  s1_dest_r;
	logic [31:0] s1_a_r;
	logic [31:0] s1_b_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_valid_r <= 1'b0;
			s1_flags_r <= 1'b0;
			s1_dest_r  <= 7'h00;
			s1_a_r     <= 32'h00000000;
			s1_b_r     <= 32'h00000000;
		end else begin
			s1_valid_r <= accept && guard_ok; // [RULE_13] [RULE_17]
			s1_flags_r <= op_flags;
			s1_dest_r  <= req.dest;
			s1_a_r     <= req.first_source_register;
			s1_b_r     <= req.second_source_register;
		end
	end

	// ---------------- stage 2: classify and multiply ----------------
	wire logic a_dn   = is_denorm(s1_a_r);
	wire logic b_dn   = is_denorm(s1_b_r);
	wire logic a_zero = is_zero_exp(s1_a_r); // [RULE_07]
	wire logic b_zero = is_zero_exp(s1_b_r); // [RULE_07]
	wire logic a_inf  = is_inf(s1_a_r);
	wire logic b_inf  = is_inf(s1_b_r);
	wire logic a_nan  = is_nan(s1_a_r);
	wire logic b_nan  = is_nan(s1_b_r);
	wire logic any_snan = (a_nan && !s1_a_r[22]) || (b_nan && !s1_b_r[22]);
	wire logic inv_mul  = (a_inf && b_zero) || (b_inf && a_zero); // [RULE_18]
	wire logic [47:0] prod = {1'b1, s1_a_r[22:0]} * {1'b1, s1_b_r[22:0]}; // [RULE_01]
	wire logic signed [9:0] exp_sum = $signed({2'b00, s1_a_r[30:23]} + {2'b00, s1_b_r[30:23]}
		- FMU_BIAS);

	logic        s2_valid_r;
	logic        s2_flags_r;
	logic [6:0]  s2_dest_r;
	logic        s2_sign_r;
	logic [47:0] s2_prod_r;
	logic signed [9:0] s2_exp_r;
	logic        s2_nan_r;
	logic        s2_inv_r;
	logic        s2_inf_r;
	logic        s2_zero_r;
	logic        s2_ifz_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s2_valid_r <= 1'b0;
			s2_flags_r <= 1'b0;
			s2_dest_r  <= 7'h00;
			s2_sign_r  <= 1'b0;
			s2_prod_r  <= 48'h000000000000;
			s2_exp_r   <= 10'sh000;
			s2_nan_r   <= 1'b0;
			s2_inv_r   <= 1'b0;
			s2_inf_r   <= 1'b0;
			s2_zero_r  <= 1'b0;
			s2_ifz_r   <= 1'b0;
		end else begin
			s2_valid_r <= s1_valid_r;
			s2_flags_r <= s1_flags_r;
			s2_dest_r  <= s1_dest_r;
			s2_sign_r  <= s1_a_r[31] ^ s1_b_r[31];
			s2_prod_r  <= prod;
			s2_exp_r   <= exp_sum;
			s2_nan_r   <= a_nan || b_nan || inv_mul;
			s2_inv_r   <= inv_mul || any_snan; // [RULE_18] [RULE_09]
			s2_inf_r   <= a_inf || b_inf;
			s2_zero_r  <= a_zero || b_zero;
			s2_ifz_r   <= a_dn || b_dn; // [RULE_07] [RULE_16]
		end
	end

	// ---------------- stage 3: normalise, round, pack ----------------
	logic [9:0] psw_r;
	logic [FMU_EV_W-1:0] irq_stat_r;
	logic [FMU_EV_W-1:0] irq_mask_r;
	fmu_rmode_t rmode;
	assign rmode = fmu_rmode_t'(psw_r[FMU_RM_MSB:FMU_RM_LSB]); // [RULE_06]

	wire logic        hi      = s2_prod_r[47];
	wire logic [23:0] mant    = hi ? s2_prod_r[47:24] : s2_prod_r[46:23];
	wire logic [23:0] rest    = hi ? s2_prod_r[23:0] : {s2_prod_r[22:0], 1'b0};
	wire logic signed [9:0] e_n = hi ? s2_exp_r + 10'sd1 : s2_exp_r;
	wire logic        rbit    = rest[23];
	wire logic        sbit    = |rest[22:0];
	wire logic        lost    = rbit || sbit;
	wire logic        rnd_inc = (rmode == FMU_RM_NEAREST) ? (rbit && (sbit || mant[0])) :
		(rmode == FMU_RM_POS) ? (!s2_sign_r && lost) :
		(rmode == FMU_RM_NEG) ? (s2_sign_r && lost) : 1'b0; // [RULE_06]
	wire logic [31:0] packed_sum = {1'b0, e_n[7:0], mant[22:0]} + {31'h0, rnd_inc};
	wire logic        under   = e_n < 10'sd1;
	wire logic        over    = (e_n > 10'sd254) || (packed_sum[30:23] == FMU_EXP_MAX);
	wire logic        to_max  = (rmode == FMU_RM_ZERO) || (rmode == FMU_RM_POS && s2_sign_r)
		|| (rmode == FMU_RM_NEG && !s2_sign_r);

	logic [31:0] res;
	logic [FMU_FLAG_W-1:0] fl;

	always_comb begin
		res = {s2_sign_r, packed_sum[30:0]};
		fl  = '0;
		fl[FMU_B_IFZ] = s2_ifz_r; // [RULE_07] [RULE_16]
		if (s2_nan_r) begin
			res = FMU_QNAN; // [RULE_18]
			fl[FMU_B_INV] = s2_inv_r;
		end else if (s2_inf_r) begin
			res = {s2_sign_r, FMU_EXP_MAX, 23'h000000};
		end else if (s2_zero_r) begin
			res = {s2_sign_r, 31'h00000000};
		end else if (under) begin
			res = 32'h00000000; // [RULE_08]
			fl[FMU_B_UNF] = 1'b1;
			fl[FMU_B_INX] = 1'b1;
			fl[FMU_B_OFZ] = e_n >= FMU_DENORM_FLOOR; // [RULE_08] [RULE_16]
		end else if (over) begin
			res = {s2_sign_r, to_max ? FMU_MAX_FIN : {FMU_EXP_MAX, 23'h000000}};
			fl[FMU_B_OVF] = 1'b1; // [RULE_09]
			fl[FMU_B_INX] = 1'b1;
		end else begin
			fl[FMU_B_INX] = lost; // [RULE_09]
		end
	end

	wire logic [31:0] flag_vec = {25'h0000000, fl}; // [RULE_15]
	wire logic        mul_upd  = s2_valid_r && !s2_flags_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wb <= '0;
		end else begin
			wb.valid <= s2_valid_r; // [RULE_02]
			wb.dest  <= s2_dest_r;
			wb.data  <= s2_flags_r ? flag_vec : res; // [RULE_14] [RULE_01]
		end
	end

	// ---------------- apb slave and status word ----------------
	wire logic setup    = psel && !penable;
	wire logic access   = psel && penable && pready;
	wire logic hit_psw  = paddr == FMU_OFS_PSW;
	wire logic hit_stat = paddr == FMU_OFS_IRQ_STAT;
	wire logic hit_mask = paddr == FMU_OFS_IRQ_MASK;
	wire logic mapped   = hit_psw || hit_stat || hit_mask;
	wire logic wr_psw   = access && pwrite && hit_psw;
	wire logic wr_stat  = access && pwrite && hit_stat;
	wire logic wr_mask  = access && pwrite && hit_mask;

	wire logic [31:0] rd_mux = hit_psw ? {22'h000000, psw_r} :
		hit_stat ? {29'h00000000, irq_stat_r} :
		hit_mask ? {29'h00000000, irq_mask_r} : 32'h00000000;

	// hardware sets are ored in after any software write, so a set never gets lost
	wire logic [6:0] hw_set  = ext_flag_set | (mul_upd ? fl : 7'h00); // [RULE_12] [RULE_11]
	wire logic [6:0] fl_base = wr_psw ? pwdata[6:0] : psw_r[6:0]; // [RULE_10]
	wire logic [1:0] rm_nxt  = wr_psw ? pwdata[FMU_RM_MSB:FMU_RM_LSB] : psw_r[FMU_RM_MSB:FMU_RM_LSB];
	wire logic [9:0] psw_nxt = {rm_nxt, 1'b0, fl_base | hw_set}; // [RULE_10] [RULE_12]

	wire logic [FMU_EV_W-1:0] ev = {refused, mul_upd && (fl != 7'h00), s2_valid_r};
	wire logic [FMU_EV_W-1:0] stat_nxt =
		(irq_stat_r & ~(wr_stat ? pwdata[FMU_EV_W-1:0] : '0)) | ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psw_r      <= 10'h000;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			irq        <= 1'b0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h00000000;
		end else begin
			psw_r      <= psw_nxt; // [RULE_11]
			irq_stat_r <= stat_nxt;
			irq_mask_r <= wr_mask ? pwdata[FMU_EV_W-1:0] : irq_mask_r;
			irq        <= |(stat_nxt & (wr_mask ? pwdata[FMU_EV_W-1:0] : irq_mask_r));
			pready     <= setup;
			pslverr    <= setup && !mapped;
			prdata     <= (setup && !pwrite) ? rd_mux : prdata;
		end
	end

	assign program_status_word = {22'h000000, psw_r};

	// ---------------- checks ----------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_issue_live;
		accept && guard_ok;
	endsequence

	sequence s_issue_dead;
		accept && !guard_ok;
	endsequence

	sequence s_issue_mul_inv;
		accept && guard_ok && op_mul
		&& is_inf(req.first_source_register) && (req.second_source_register[30:0] == 31'h0);
	endsequence

	chk_latency_three: assert property (s_issue_live
		|-> ##3 (wb.valid && wb.dest == $past(req.dest, 3))) // [RULE_02]
		else $error("result not delivered three cycles after issue");

	chk_guard_false: assert property (s_issue_dead |-> ##3 !wb.valid) // [RULE_13] [RULE_17]
		else $error("false guard still wrote destination");

	chk_slot_refuse: assert property (req.valid && !slot_ok |=> irq_stat_r[FMU_EV_REFU]
		##2 !wb.valid) // [RULE_05]
		else $error("issue in illegal slot was not refused");

	chk_flags_sticky: assert property (!$past(wr_psw)
		|-> (psw_r[6:0] & $past(psw_r[6:0])) == $past(psw_r[6:0])) // [RULE_10]
		else $error("status flag dropped without a status write");

	chk_flags_op_quiet: assert property (s2_valid_r && s2_flags_r && !wr_psw
		&& ext_flag_set == 7'h00 |=> psw_r[6:0] == $past(psw_r[6:0])) // [RULE_14]
		else $error("flags operation changed the status flags");

	chk_flag_layout: assert property (wb.valid && $past(s2_flags_r)
		|-> wb.data[31:7] == 25'h0 && !wb.data[FMU_B_DBZ]) // [RULE_15]
		else $error("flag vector has bits outside its layout");

	chk_invalid_nan: assert property (s_issue_mul_inv |-> ##3 (wb.data == FMU_QNAN
		&& psw_r[FMU_B_INV])) // [RULE_18]
		else $error("inf times zero did not give all-ones nan and invalid");

	chk_ifz_mul: assert property (s_issue_live ##0 (op_mul
		&& (is_denorm(req.first_source_register) || is_denorm(req.second_source_register)))
		|-> ##3 psw_r[FMU_B_IFZ]) // [RULE_07]
		else $error("denormal input did not set input-flush flag");

	chk_psw_or_merge: assert property (mul_upd && !wr_psw
		|=> psw_r[6:0] == ($past(psw_r[6:0]) | $past(fl) | $past(ext_flag_set))) // [RULE_12]
		else $error("status flags not the or of all updates");

	chk_irq_level: assert property (irq == |($past(stat_nxt) & $past(irq_mask_r))
		|| $past(wr_mask))
		else $error("interrupt line does not follow status and mask");

endmodule // fmu_mul_unit

// ### test/fmu_issue_model.sv
// issue pipeline and register file model facing the multiply unit
`timescale 1ns/1ps
module fmu_issue_model
	import fmu_pkg::*;
(
	input  wire logic    pclk,
	output fmu_req_t     req,
	input  wire fmu_wb_t wb
);
	logic [31:0] regs [128];
	int          lat  [128];
	int          iss  [128];
	int          cyc;

	initial begin
		req = '0;
		cyc = 0;
		for (int i = 0; i < 128; i++) begin
			regs[i] = 32'h5A5A5A5A;
			lat[i]  = 0;
		end
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (wb.valid === 1'b1) begin
			regs[wb.dest] <= wb.data;
			// issue sampled at edge n, wb sampled at edge n+3
			lat[wb.dest] <= cyc - iss[wb.dest];
		end
	end

	// slots two and three, other slots only when a test wants a refusal
	task automatic issue(input logic [2:0] slot, input logic [7:0] opc, input logic gu,
		input logic gl, input logic [31:0] a, input logic [31:0] b, input logic [6:0] d);
		req <= '{1'b1, slot, opc, gu, gl, a, b, d};
		@(posedge pclk);
		iss[d] = cyc;
	endtask

	// released operands show the inverse, not the last value
	task automatic idle();
		req.valid                  <= 1'b0;
		req.first_source_register  <= ~req.first_source_register;
		req.second_source_register <= ~req.second_source_register;
	endtask
endmodule // fmu_issue_model

// ### test/fp_multiply_unit_bench.sv
// self-checking bench for the float multiply unit
`timescale 1ns/1ps
module fp_multiply_unit_bench import fmu_pkg::*;;
	typedef struct {
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] r;
		logic [6:0]  f;
		logic [1:0]  rm;
	} fmu_case_t;

	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	fmu_req_t    req;
	logic [6:0]  ext_flag_set;
	fmu_wb_t     wb;
	logic [31:0] program_status_word;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          errors = 0;
	int          comparisons = 0;
	fmu_case_t   cs [14] = '{
		'{32'hC0400000, 32'h3F800000, 32'hC0400000, 7'h00, 2'h0},
		'{32'h40400000, 32'hC0400000, 32'hC1100000, 7'h00, 2'h0},
		'{32'h40400000, 32'h00800000, 32'h01400000, 7'h00, 2'h0},
		'{32'h3F000000, 32'h00800000, 32'h00000000, 7'h46, 2'h0},
		'{32'h7F800000, 32'h00000000, 32'hFFFFFFFF, 7'h10, 2'h0},
		'{32'h40400000, 32'h00400000, 32'h00000000, 7'h20, 2'h0},
		'{32'h00C00000, 32'h80800000, 32'h00000000, 7'h06, 2'h0},
		'{32'h7F800000, 32'hFF800000, 32'hFF800000, 7'h00, 2'h0},
		'{32'h7F7FFFFF, 32'h7F7FFFFF, 32'h7F800000, 7'h0A, 2'h0},
		'{32'h00800000, 32'h00800000, 32'h00000000, 7'h06, 2'h0},
		'{32'h7F7FFFFF, 32'h7F7FFFFF, 32'h7F7FFFFF, 7'h0A, 2'h1},
		'{32'h3F800001, 32'h3F800001, 32'h3F800003, 7'h02, 2'h2},
		'{32'hBF800001, 32'h3F800001, 32'hBF800003, 7'h02, 2'h3},
		'{32'h3F800001, 32'h3F800001, 32'h3F800002, 7'h02, 2'h0}};

	always #20 pclk = ~pclk;

	fmu_mul_unit dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req(req), .ext_flag_set(ext_flag_set), .wb(wb),
		.program_status_word(program_status_word), .irq(irq));

	fmu_issue_model u (.pclk(pclk), .req(req), .wb(wb));

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, ext_flag_set} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, FMU_OFS_PSW, 32'h0);
		check("status reset", rd, 32'h0);
		apb(1'b1, FMU_OFS_IRQ_MASK, 32'h4);
		for (int i = 0; i < 14; i++) begin
			apb(1'b1, FMU_OFS_PSW, {22'h0, cs[i].rm, 8'h00});
			u.issue(i[0] ? FMU_SLOT_HI : FMU_SLOT_LO, FMU_OPC_MUL, 1'b0, 1'b0, cs[i].a, cs[i].b,
				7'(i));
			u.issue(i[0] ? FMU_SLOT_LO : FMU_SLOT_HI, FMU_OPC_MUL_FLAGS, 1'b0, 1'b0, cs[i].a,
				cs[i].b, 7'(i + 32));
			u.idle();
			repeat (6) @(posedge pclk);
			check("product", u.regs[i], cs[i].r);
			check("flag vector", u.regs[i + 32], {25'h0, cs[i].f});
			check("status", program_status_word, {22'h0, cs[i].rm, 1'b0, cs[i].f});
			check("mul latency", 32'(u.lat[i]), 32'(FMU_LATENCY));
			check("flags latency", 32'(u.lat[i + 32]), 32'(FMU_LATENCY));
		end
		check("irq masked", {31'h0, irq}, 32'h0);
		u.issue(3'h1, FMU_OPC_MUL, 1'b0, 1'b0, 32'h40400000, 32'h40400000, 7'h46);
		u.issue(3'h4, FMU_OPC_MUL_FLAGS, 1'b0, 1'b0, 32'h40400000, 32'h3F000000, 7'h47);
		u.issue(FMU_SLOT_LO, 8'h1D, 1'b0, 1'b0, 32'h40400000, 32'h40400000, 7'h48);
		u.idle();
		repeat (6) @(posedge pclk);
		for (int k = 70; k < 73; k++) begin
			check("refused dest", u.regs[k], 32'h5A5A5A5A);
		end
		check("irq raised", {31'h0, irq}, 32'h1);
		apb(1'b0, FMU_OFS_IRQ_STAT, 32'h0);
		check("irq status", rd, 32'h7);
		apb(1'b1, FMU_OFS_IRQ_STAT, 32'h7);
		apb(1'b0, FMU_OFS_IRQ_STAT, 32'h0);
		check("irq status cleared", rd, 32'h0);
		check("irq cleared", {31'h0, irq}, 32'h0);
		apb(1'b0, FMU_OFS_IRQ_MASK, 32'h0);
		check("irq mask", rd, 32'h4);
		apb(1'b0, 12'h00C, 32'h0);
		check("unmapped data", rd, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
		apb(1'b1, FMU_OFS_PSW, 32'h0);
		u.issue(FMU_SLOT_LO, FMU_OPC_MUL, 1'b0, 1'b0, 32'h7F7FFFFF, 32'h7F7FFFFF, 7'h50);
		u.idle();
		@(posedge pclk);
		// other unit's flag lands on the writeback edge
		ext_flag_set <= 7'h01;
		@(posedge pclk);
		ext_flag_set <= 7'h00;
		repeat (3) @(posedge pclk);
		check("merged flags", program_status_word, 32'h0B);
		u.issue(FMU_SLOT_HI, FMU_OPC_MUL, 1'b1, 1'b1, 32'h40400000, 32'hC0400000, 7'h51);
		u.issue(FMU_SLOT_LO, FMU_OPC_MUL, 1'b1, 1'b0, 32'h7F800000, 32'h0, 7'h52);
		u.issue(FMU_SLOT_HI, FMU_OPC_MUL_FLAGS, 1'b1, 1'b0, 32'h7F800000, 32'h0, 7'h53);
		u.idle();
		repeat (6) @(posedge pclk);
		check("guard true", u.regs[81], 32'hC1100000);
		check("guard false", u.regs[82], 32'h5A5A5A5A);
		check("guard false vector", u.regs[83], 32'h5A5A5A5A);
		check("sticky flags", program_status_word, 32'h0B);
		apb(1'b1, FMU_OFS_PSW, 32'h0);
		@(posedge pclk);
		check("flags written", program_status_word, 32'h0);
		give_verdict();
	end
endmodule // fp_multiply_unit_bench
